// ### rtl/sac_ctrl.sv
// Control and readout section of a 12-bit successive-approximation converter.
// Assumes control pins and the comparator are asynchronous to sys_clk, and
// that the pad ring forms the tri-state data bus from data_out/data_oe_n.
`timescale 1ns/10ps
module sac_ctrl #(
  parameter int CONV_DIV = sac_pkg::CONV_DIV
) (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic                       enable_in,
  input  wire logic                       select_n,
  input  wire logic                       read_convert,
  input  wire logic                       word_select,
  input  wire logic                       byte_select,
  input  wire logic                       cmp_higher,
  input  wire logic [sac_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [sac_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [sac_pkg::REG_DW-1:0] reg_rdata,
  output logic                            busy_flag,
  output logic      [11:0]                data_out,
  output logic      [11:0]                data_oe_n,
  output logic      [11:0]                dac_code,
  output logic                            track_en,
  output logic                            irq
);

  // The comparator answer crosses a two-stage synchroniser, so a trial needs
  // at least four system clocks before its decision is taken
  if (CONV_DIV < 4) begin : g_bad_div
    $error("sac_ctrl: CONV_DIV must be at least 4");
  end

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [5:0] pins_s;
  logic       en_s;
  logic       sel_n_s;
  logic       rc_s;
  logic       word_s;
  logic       a0_s;
  logic       cmp_s;
  logic       conv_tick;

  sac_sync #(
    .W (6)
  ) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .d       ({enable_in, select_n, read_convert, word_select, byte_select, cmp_higher}),
    .q       (pins_s)
  );

  assign {en_s, sel_n_s, rc_s, word_s, a0_s, cmp_s} = pins_s;

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  logic busy_r;

  // Clock runs only while busy, so every conversion starts on a fresh period
  sac_tick #(
    .DIV (CONV_DIV)
  ) u_tick (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .run     (busy_r),
    .tick    (conv_tick)
  );

  function automatic logic [11:0] bit_mask(input logic [3:0] idx);
    bit_mask = 12'h001 << idx;
  endfunction

  // Sets the trial bit when the comparator says the input is still higher
  function automatic logic [11:0] keep_bit(input logic [11:0] code,
                                           input logic [3:0]  idx,
                                           input logic        keep);
    keep_bit = keep ? (code | bit_mask(idx)) : code;
  endfunction

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  sac_pkg::sac_state_e state_r;
  sac_pkg::sac_state_e state_nxt;
  logic                busy_nxt;
  logic                start_cond;
  logic                start_q_r;
  logic                start_q_nxt;
  logic                start_edge;
  logic                len8_r;
  logic                len8_nxt;
  logic [1:0]          acq_r;
  logic [1:0]          acq_nxt;
  logic [3:0]          idx_r;
  logic [3:0]          idx_nxt;
  logic [3:0]          stop_idx;
  logic [11:0]         sar_r;
  logic [11:0]         sar_nxt;
  logic [11:0]         result_r;
  logic [11:0]         result_nxt;
  logic [11:0]         dac_r;
  logic [11:0]         dac_nxt;
  logic                track_r;
  logic                track_nxt;
  logic                done_ev;
  logic                restart_ev;

  // Start is the rising edge of the combined level, so whichever input
  // arrives last is the one that fires it
  assign start_cond = en_s & ~sel_n_s & ~rc_s;
  assign start_edge = start_cond & ~start_q_r;
  // Compare with <= so a late switch to eight bits still ends the run
  assign stop_idx   = len8_r ? sac_pkg::STOP_SHORT : sac_pkg::STOP_FULL;

  // Next-state logic for acquisition and bit trials
  always_comb begin
    state_nxt   = state_r;
    busy_nxt    = busy_r;
    start_q_nxt = start_cond;
    len8_nxt    = len8_r;
    acq_nxt     = acq_r;
    idx_nxt     = idx_r;
    sar_nxt     = sar_r;
    result_nxt  = result_r;
    done_ev     = 1'b0;
    restart_ev  = 1'b0;
    unique case (state_r)
      sac_pkg::ST_IDLE: begin
        if (start_edge) begin
          state_nxt = sac_pkg::ST_ACQ;
          busy_nxt  = 1'b1;
          len8_nxt  = a0_s;
          acq_nxt   = 2'h0;
          sar_nxt   = 12'h000;
        end
      end
      sac_pkg::ST_ACQ: begin
        if (conv_tick) begin
          if (acq_r == sac_pkg::ACQ_LAST) begin
            state_nxt = sac_pkg::ST_TRIAL;
            idx_nxt   = sac_pkg::MSB_IDX;
          end else begin
            acq_nxt = acq_r + 2'h1;
          end
        end
      end
      sac_pkg::ST_TRIAL: begin
        if (conv_tick) begin
          sar_nxt = keep_bit(sar_r, idx_r, cmp_s);
          if (idx_r <= stop_idx) begin
            state_nxt  = sac_pkg::ST_IDLE;
            busy_nxt   = 1'b0;
            done_ev    = 1'b1;
            result_nxt = len8_r ? {sar_nxt[11:4], sac_pkg::SHORT_FILL} : sar_nxt;
          end else begin
            idx_nxt = idx_r - 4'h1;
          end
        end
      end
      default: begin
        state_nxt = sac_pkg::ST_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase
    // A start while busy recaptures the length and flags a restart event; the run carries on
    if (busy_r && start_edge) begin
      len8_nxt   = a0_s;
      restart_ev = 1'b1;
    end
  end

  // Analog-side drive: track only while acquiring, trial code while trying
  always_comb begin
    track_nxt = (state_nxt == sac_pkg::ST_ACQ);
    dac_nxt   = 12'h000;
    if (state_nxt == sac_pkg::ST_TRIAL) begin
      dac_nxt = sar_nxt | bit_mask(idx_nxt);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r   <= sac_pkg::ST_IDLE;
      busy_r    <= 1'b0;
      start_q_r <= 1'b0;
      len8_r    <= 1'b0;
      acq_r     <= 2'h0;
      idx_r     <= 4'h0;
      sar_r     <= 12'h000;
      result_r  <= 12'h000;
      dac_r     <= 12'h000;
      track_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      busy_r    <= busy_nxt;
      start_q_r <= start_q_nxt;
      len8_r    <= len8_nxt;
      acq_r     <= acq_nxt;
      idx_r     <= idx_nxt;
      sar_r     <= sar_nxt;
      result_r  <= result_nxt;
      dac_r     <= dac_nxt;
      track_r   <= track_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Data output groups
  // ----------------------------------------------------------------
  logic        read_ok;
  logic [2:0]  grp_want;
  logic [2:0]  grp_r;
  logic [2:0]  grp_nxt;
  logic [11:0] oe_n_r;
  logic [11:0] oe_n_nxt;
  logic [11:0] dout_r;
  logic [11:0] dout_nxt;

  // Uses busy_nxt so the buffers let go in the very cycle a run starts;
  // all controls, byte select included, are used live
  assign read_ok = rc_s & ~busy_nxt & en_s & ~sel_n_s;

  // Group choice with one idle cycle between two different groups
  always_comb begin
    grp_want = sac_pkg::GRP_NONE;
    if (read_ok) begin
      if (word_s) begin
        grp_want = sac_pkg::GRP_WORD;
      end else if (a0_s) begin
        grp_want = sac_pkg::GRP_LSB;
      end else begin
        grp_want = sac_pkg::GRP_MSB;
      end
    end
    grp_nxt = grp_want;
    if (grp_r != sac_pkg::GRP_NONE && grp_want != sac_pkg::GRP_NONE && grp_want != grp_r) begin
      grp_nxt = sac_pkg::GRP_NONE;
    end
    oe_n_nxt = ~{{4{grp_nxt[2]}}, {4{grp_nxt[1]}}, {4{grp_nxt[0]}}};
    dout_nxt = result_nxt & ~oe_n_nxt;
    if (grp_nxt == sac_pkg::GRP_LSB) begin
      dout_nxt[7:4] = 4'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      grp_r  <= sac_pkg::GRP_NONE;
      oe_n_r <= 12'hfff;
      dout_r <= 12'h000;
    end else begin
      grp_r  <= grp_nxt;
      oe_n_r <= oe_n_nxt;
      dout_r <= dout_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register port and interrupt
  // ----------------------------------------------------------------
  logic [1:0]  status_r;
  logic [1:0]  status_nxt;
  logic [1:0]  mask_r;
  logic [1:0]  mask_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  // Event sets are applied after the clear, so a set wins a tie
  always_comb begin
    status_nxt = status_r;
    mask_nxt   = mask_r;
    if (reg_wr && reg_addr == sac_pkg::REG_STATUS) begin
      status_nxt = status_r & ~reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == sac_pkg::REG_MASK) begin
      mask_nxt = reg_wdata[1:0];
    end
    if (done_ev) begin
      status_nxt[sac_pkg::EV_DONE] = 1'b1;
    end
    if (restart_ev) begin
      status_nxt[sac_pkg::EV_RESTART] = 1'b1;
    end
    irq_nxt   = |(status_nxt & mask_nxt);
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        sac_pkg::REG_STATUS: rdata_nxt = {14'h0000, status_r};
        sac_pkg::REG_MASK:   rdata_nxt = {14'h0000, mask_r};
        sac_pkg::REG_RESULT: rdata_nxt = {busy_r, len8_r, 2'h0, result_r};
        default:             rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      status_r <= sac_pkg::STATUS_RST;
      mask_r   <= sac_pkg::MASK_RST;
      irq_r    <= 1'b0;
      rdata_r  <= 16'h0000;
    end else begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      irq_r    <= irq_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // Every output straight from a flip-flop
  assign reg_rdata = rdata_r;
  assign busy_flag = busy_r;
  assign data_out  = dout_r;
  assign data_oe_n = oe_n_r;
  assign dac_code  = dac_r;
  assign track_en  = track_r;
  assign irq       = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_idle_start;
    state_r == sac_pkg::ST_IDLE && start_edge;
  endsequence

  sequence s_clean_acq;
    state_r == sac_pkg::ST_ACQ && track_en && sar_r == 12'h000;
  endsequence

  property p_start_acq;
    @(posedge sys_clk) disable iff (!resetn) s_idle_start |=> s_clean_acq;
  endproperty

  AST_START_ACQ: assert property (p_start_acq)
    else $error("start did not enter a cleared acquisition");

  AST_ACQ_TWO: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_r == sac_pkg::ST_ACQ && conv_tick && acq_r == sac_pkg::ACQ_LAST
    |=> state_r == sac_pkg::ST_TRIAL && idx_r == sac_pkg::MSB_IDX && !track_en)
    else $error("acquisition did not end after two ticks");

  AST_BUSY_STATE: assert property (@(posedge sys_clk) disable iff (!resetn)
    busy_flag == (state_r != sac_pkg::ST_IDLE))
    else $error("busy flag disagrees with the sequencer");

  AST_BUSY_RELEASE: assert property (@(posedge sys_clk) disable iff (!resetn)
    busy_flag |-> data_oe_n == 12'hfff)
    else $error("data driven while busy");

  AST_NO_RESTART: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_r == sac_pkg::ST_TRIAL && start_edge && !conv_tick
    |=> state_r == sac_pkg::ST_TRIAL && $stable(idx_r))
    else $error("start during a run disturbed the trials");

  AST_SHORT_FILL: assert property (@(posedge sys_clk) disable iff (!resetn)
    done_ev && len8_r |=> result_r[3:0] == sac_pkg::SHORT_FILL)
    else $error("short result low nibble wrong");

  AST_READ_GATE: assert property (@(posedge sys_clk) disable iff (!resetn)
    data_oe_n != 12'hfff |-> $past(read_ok))
    else $error("outputs enabled without all read conditions");

  AST_BREAK_MAKE: assert property (@(posedge sys_clk) disable iff (!resetn)
    grp_r != sac_pkg::GRP_NONE |=> grp_r == $past(grp_r) || grp_r == sac_pkg::GRP_NONE)
    else $error("output groups switched without a release");

endmodule

// ### rtl/sac_pkg.sv
// Shared constants for the APPROXIMATION_REGISTER converter control and readout block.
// Assumes a single 50 MHz system clock; every other rate is an enable pulse.
package sac_pkg;

  // ----------------------------------------------------------------
  // Conversion geometry
  // ----------------------------------------------------------------
  localparam int         RES_BITS       = 12;
  localparam int         IDX_W          = 4;
  localparam logic [3:0] MSB_IDX        = 4'hb;     // First trial bit
  localparam logic [3:0] STOP_SHORT     = 4'h4;     // Last trial of an 8-bit run
  localparam logic [3:0] STOP_FULL      = 4'h0;     // Last trial of a 12-bit run
  localparam logic [3:0] SHORT_FILL     = 4'h8;     // Low nibble after an 8-bit run
  localparam logic [1:0] ACQ_LAST       = 2'h1;     // Two acquisition ticks: 0 and 1

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         SYS_CLK_NS     = 20;
  localparam int         CONV_CLK_NS    = 1000;     // Internal conversion clock period
  localparam int         CONV_DIV       = (CONV_CLK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // ----------------------------------------------------------------
  // Output groups: bit 2 = data 11..8, bit 1 = data 7..4, bit 0 = data 3..0
  // ----------------------------------------------------------------
  localparam logic [2:0] GRP_NONE       = 3'h0;
  localparam logic [2:0] GRP_WORD       = 3'h7;
  localparam logic [2:0] GRP_MSB        = 3'h6;
  localparam logic [2:0] GRP_LSB        = 3'h3;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int         REG_AW         = 4;
  localparam int         REG_DW         = 16;
  localparam logic [3:0] REG_STATUS     = 4'h0;     // Sticky events, write one to clear
  localparam logic [3:0] REG_MASK       = 4'h4;     // Interrupt mask, same layout
  localparam logic [3:0] REG_RESULT     = 4'h8;     // Busy, length, last result
  localparam int         EV_W           = 2;
  localparam int         EV_DONE        = 0;
  localparam int         EV_RESTART     = 1;
  localparam int         RES_BUSY_BIT   = 15;
  localparam int         RES_LEN8_BIT   = 14;
  localparam logic [1:0] STATUS_RST     = 2'h0;
  localparam logic [1:0] MASK_RST       = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ,
    ST_TRIAL
  } sac_state_e;

endpackage

// ### rtl/sac_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent level; no bus coherency is implied.
`timescale 1ns/10ps
module sac_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// ### rtl/sac_tick.sv
// Divider producing the internal conversion clock as a one-cycle enable.
// Assumes run is low between conversions so each run starts a full period.
`timescale 1ns/10ps
module sac_tick #(
  parameter int DIV = 50
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic run,
  output logic      tick
);

  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          tick_r;
  logic          tick_nxt;

  if (DIV < 2) begin : g_bad_div
    $error("sac_tick: DIV must be at least 2");
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Stopped clock holds at zero, which is how the clock is gated off
  always_comb begin
    cnt_nxt  = '0;
    tick_nxt = 1'b0;
    if (run) begin
      if (cnt_r == CW'(DIV - 1)) begin
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

// ### verif/sac_cmp_model.sv
// Comparator and sampling capacitor model at the far side of the core.
// Assumes the core raises track_en only while it acquires the input.
`timescale 1ns/10ps
module sac_cmp_model (
  input  wire logic        track_en,
  input  wire logic [11:0] vin,
  input  wire logic [11:0] dac_code,
  output logic             cmp_higher
);
  logic [11:0] held;
  // Sample is frozen once tracking ends, so later input moves go unseen
  always_latch if (track_en) held <= vin;
  // Trial bit kept while the held input is not below the trial code
  assign cmp_higher = (held >= dac_code);
endmodule

// ### verif/testbench.sv
// Self-checking bench for the converter control and readout block.
// Assumes the comparator model holds the analog input as a 12-bit code.
`timescale 1ns/10ps
module testbench;
  logic        sys_clk = 1'h0, resetn = 1'h0, enable_in = 1'h0, select_n = 1'h1;
  logic        read_convert = 1'h1, word_select = 1'h1, byte_select = 1'h0;
  logic        reg_wr = 1'h0, reg_rd = 1'h0, cmp_higher, busy_flag, track_en, irq;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata;
  logic [11:0] vin = 12'h0, data_out, data_oe_n, dac_code;
  int          bad_count = 0, comparisons = 0;
  // ------------------------------------------------------------
  // Clock, design and far-side model
  // ------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;
  sac_ctrl #(.CONV_DIV(4)) dut_u (.sys_clk(sys_clk), .resetn(resetn), .enable_in(enable_in),
    .select_n(select_n), .read_convert(read_convert), .word_select(word_select),
    .byte_select(byte_select), .cmp_higher(cmp_higher), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .busy_flag(busy_flag), .data_out(data_out), .data_oe_n(data_oe_n),
    .dac_code(dac_code), .track_en(track_en), .irq(irq));
  sac_cmp_model cmp_u (.track_en(track_en), .vin(vin), .dac_code(dac_code),
    .cmp_higher(cmp_higher));
  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait on busy; ends on a rising edge so drivers may follow
  task automatic wait_busy(input logic lvl);
    for (int n = 0; busy_flag !== lvl; n++) begin
      @(negedge sys_clk);
      if (n > 2000) begin
        bad_count++;
        summarize();
      end
    end
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    @(negedge sys_clk);
    chk(exp, reg_rdata & m);
  endtask
  // Pins pass a synchroniser, so allow a few cycles to settle
  task automatic rdpin(input logic ws, input logic bs, input logic [11:0] oe,
                       input logic [11:0] d);
    @(posedge sys_clk);
    word_select <= ws;
    byte_select <= bs;
    repeat (8) @(negedge sys_clk);
    chk(oe, data_oe_n);
    chk(d, data_out & ~data_oe_n);
  endtask
  function automatic logic [11:0] expect_word(input logic bs, input logic [11:0] v);
    return bs ? {v[11:4], 4'h8} : v;
  endfunction
  // One conversion started by input m, optional restart, then all reads
  task automatic conv(input int m, input logic bs, input logic [11:0] v, input logic r);
    logic [11:0] e;
    @(posedge sys_clk);
    vin <= v;
    byte_select <= bs;
    enable_in <= 1'(m != 0);
    select_n <= 1'(m == 1);
    read_convert <= 1'(m == 2);
    repeat (4) @(posedge sys_clk);
    enable_in <= 1'h1;
    select_n <= 1'h0;
    read_convert <= 1'h0;
    wait_busy(1'h1);
    read_convert <= 1'h1;
    if (r) begin
      repeat (4) @(posedge sys_clk);
      byte_select <= ~bs;
      read_convert <= 1'h0;
      repeat (3) @(posedge sys_clk);
      read_convert <= 1'h1;
    end
    repeat (4) @(negedge sys_clk);
    chk(16'h0fff, data_oe_n);
    wait_busy(1'h0);
    e = expect_word(bs ^ r, v);
    rdpin(1'h1, 1'h0, 12'h000, e);
    rdpin(1'h1, 1'h1, 12'h000, e);
    rdpin(1'h0, 1'h0, 12'h00f, {e[11:4], 4'h0});
    rdpin(1'h0, 1'h1, 12'hf00, {8'h0, e[3:0]});
    @(posedge sys_clk);
    select_n <= 1'h1;
    repeat (8) @(negedge sys_clk);
    chk(16'h0fff, data_oe_n);
  endtask
  // ------------------------------------------------------------
  // Main sequence: reset values, masked and unmasked events, traffic
  // ------------------------------------------------------------
  initial begin
    void'($urandom(45130));
    repeat (5) @(posedge sys_clk);
    resetn <= 1'h1;
    rd(sac_pkg::REG_STATUS, 16'h0003, {14'h0, sac_pkg::STATUS_RST});
    rd(sac_pkg::REG_MASK, 16'h0003, {14'h0, sac_pkg::MASK_RST});
    conv(0, 1'h0, 12'hfff, 1'h0);
    rd(sac_pkg::REG_RESULT, 16'hcfff, 16'h0fff);
    chk(16'h0, irq);
    wr(sac_pkg::REG_MASK, 16'h0001);
    repeat (2) @(negedge sys_clk);
    chk(16'h1, irq);
    for (int i = 0; i < 9; i++)
      conv(i % 3, 1'($urandom), (i == 1) ? 12'h000 : 12'($urandom), 1'(i == 4 || i == 7));
    wr(sac_pkg::REG_STATUS, 16'h0003);
    repeat (2) @(negedge sys_clk);
    chk(16'h0, irq);
    rd(4'hc, 16'hffff, 16'h0000);
    summarize();
  end
endmodule
